/* File: core/tsh_cfg.svh */
// Purpose: constants of the type-B edge shaper: register indices, field positions, resets
// Assumes: register byte address is four times the register index
// Notes:   definitions only
`ifndef TSH_CFG_SVH
`define TSH_CFG_SVH

// ****************************************************************
// register indices (byte address = index * 4)
// ****************************************************************
`define TSH_IDX_KIND        8'h29
`define TSH_IDX_SHAPE       8'h2A
`define TSH_IDX_DURATION    8'h2B
`define TSH_IDX_RESIDUAL    8'h2C

// ****************************************************************
// field positions
// ****************************************************************
`define TSH_KIND_FALL_HI    7
`define TSH_KIND_FALL_LO    4
`define TSH_KIND_RISE_HI    3
`define TSH_KIND_RISE_LO    0
`define TSH_SHAPE_FALL_HI   6
`define TSH_SHAPE_FALL_LO   4
`define TSH_SHAPE_RISE_HI   2
`define TSH_SHAPE_RISE_LO   0
`define TSH_DUR_SCALE_BIT   7
`define TSH_DUR_COUNT_HI    4
`define TSH_DUR_COUNT_LO    0

// ****************************************************************
// writable masks, reset values, edge codes
// ****************************************************************
`define TSH_SHAPE_MASK      8'h77
`define TSH_DUR_MASK        8'h9F
`define TSH_RST_KIND        8'h11
`define TSH_RST_SHAPE       8'h00
`define TSH_RST_DURATION    8'h08
`define TSH_RST_RESIDUAL    8'h00
`define TSH_CODE_LIN1       4'h1
`define TSH_CODE_LIN2       4'h2
`define TSH_CODE_LIN3       4'h3
`define TSH_CODE_LUT_FIXED  4'h4
`define TSH_CODE_LUT_CORR   4'h5
`define TSH_CODE_LUT_ADAPT  4'h6
`define TSH_FULL_AMPL       8'hFF
`define TSH_VDD_NOMINAL     8'h80
`define TSH_CORR_STEP       8'h04

`endif

/* File: core/tsh_edge_profile.sv */
// Purpose: amplitude of one transition state of a falling or rising edge
// Assumes: step below count, count non-zero; purely combinational
// Notes:   firmware ramps are piecewise linear, lookup ramps come from four tables
`timescale 1ns/1ps
`include "tsh_cfg.svh"

module tsh_edge_profile (
    input  wire tsh_pkg::tsh_code_t code,        // edge kind code of this edge
    input  wire logic [2:0]         shape,       // time constant or table number
    input  wire tsh_pkg::tsh_step_t step,        // current transition state
    input  wire tsh_pkg::tsh_step_t count,       // active transition states
    input  wire logic               rising,      // 1 rising edge, 0 falling edge
    input  wire tsh_pkg::tsh_byte_t low_level,   // modulated amplitude
    input  wire tsh_pkg::tsh_byte_t vdd_level,   // supply voltage, 0x80 nominal
    output logic [7:0]              level        // amplitude of this state
);
    import tsh_pkg::*;

    // ****************************************************************
    // ramp tables: four tables of eight points each, first point 0x08..0x48 .. 255 end
    // ****************************************************************
    localparam logic [7:0] LUT [32] = '{
        8'h20, 8'h40, 8'h60, 8'h80, 8'hA0, 8'hC0, 8'hE0, 8'hFF,
        8'h08, 8'h18, 8'h30, 8'h50, 8'h78, 8'hA8, 8'hD8, 8'hFF,
        8'h48, 8'h80, 8'hA8, 8'hC8, 8'hE0, 8'hF0, 8'hF8, 8'hFF,
        8'h10, 8'h30, 8'h60, 8'h80, 8'h90, 8'hB0, 8'hE0, 8'hFF
    };

    logic [12:0] frac_num;
    logic [7:0]  frac;
    logic [7:0]  bend;
    logic [15:0] acc;
    logic [7:0]  prog;
    logic [8:0]  span;
    logic [16:0] delta;

    // ****************************************************************
    // progress through the edge and its shaped form
    // ****************************************************************
    always_comb begin
        frac_num = 13'((step + 5'd1) * 8'd255);
        frac     = 8'(frac_num / {8'h00, count});
        bend     = 8'({shape, 3'b000} + 8'h10);
        acc      = 16'h0000;
        case (code)
            `TSH_CODE_LIN1: begin
                acc = {8'h00, frac};
            end
            `TSH_CODE_LIN2: begin
                if (frac < 8'h80) begin
                    acc = 16'((frac * {bend, 1'b0}) >> 7);
                end else begin
                    acc = 16'({bend, 1'b0} + (((frac - 8'h80) * (9'h100 - {bend, 1'b0})) >> 7));
                end
            end
            `TSH_CODE_LIN3: begin
                if (frac < 8'h40) begin
                    acc = 16'((frac * bend) >> 6);
                end else if (frac < 8'hC0) begin
                    acc = 16'(bend + (((frac - 8'h40) * (9'h0FF - {bend, 1'b0})) >> 7));
                end else begin
                    acc = 16'((8'hFF - bend) + (((frac - 8'hC0) * bend) >> 6));
                end
            end
            `TSH_CODE_LUT_FIXED: begin
                acc = {8'h00, LUT[{shape[1:0], frac[7:5]}]};
            end
            `TSH_CODE_LUT_CORR: begin
                acc = 16'((LUT[{shape[1:0], frac[7:5]}] * vdd_level) >> 7);
                if (frac != 8'hFF) begin
                    acc = acc + {8'h00, `TSH_CORR_STEP};
                end
            end
            `TSH_CODE_LUT_ADAPT: begin
                acc = 16'((LUT[{shape[1:0], frac[7:5]}] * vdd_level) >> 7);
            end
            default: begin
                acc = 16'h00FF;
            end
        endcase
        prog  = (acc > 16'h00FF) ? 8'hFF : acc[7:0];
        span  = 9'(`TSH_FULL_AMPL - low_level);
        delta = 17'((span * prog) >> 8);
        if (rising) begin
            level = 8'(low_level + delta[7:0]);
        end else begin
            level = 8'(`TSH_FULL_AMPL - delta[7:0]);
        end
    end

endmodule

/* File: core/tsh_edge_shaper.sv */
// Purpose: type-B 212 kbit/s transmitter edge shaper with AHB-Lite register access
// Assumes: carrier_tick pulses once per carrier cycle; inputs synchronous to hclk
// Notes:   zero wait-state slave, hresp always OKAY
`timescale 1ns/1ps
`include "tsh_cfg.svh"

// Notes on behaviour
// - upper kind nibble picks falling firmware ramps
// - code 4: table ramp, no supply adaptation
// - code 5: table ramp, adapted, with correction
// - code 6: table ramp, adapted, no correction
// - lower nibble picks rising shaping; others reserved
// - falling shape field sets firmware time constant
// - falling shape field picks table 0..3
// - rising shape field sets firmware time constant
// - rising shape field picks table 0..3
// - top duration bit doubles every transition state
// - scale clear: one carrier cycle per state
// - scale set: two carrier cycles per state
// - low five bits count active transition states
module tsh_edge_shaper (
    input  wire logic               hclk,          // bus and shaper clock
    input  wire logic               hresetn,       // asynchronous reset, active low
    input  wire logic               hsel,          // slave select
    input  wire logic [31:0]        haddr,         // byte address
    input  wire logic [1:0]         htrans,        // transfer type
    input  wire logic               hwrite,        // write when high
    input  wire logic [2:0]         hsize,         // transfer size
    input  wire logic               hready,        // bus ready in
    input  wire logic [31:0]        hwdata,        // write data
    output logic [31:0]             hrdata,        // read data
    output logic                    hreadyout,     // slave ready
    output logic                    hresp,         // response, always OKAY
    input  wire logic               carrier_tick,  // one pulse per carrier cycle
    input  wire logic               mod_request,   // high while carrier is to be lowered
    input  wire tsh_pkg::tsh_byte_t power_amp_supply_voltage, // supply, 0x80 nominal
    output tsh_pkg::tsh_byte_t      amp_level,     // carrier amplitude
    output logic                    edge_active,   // an edge pattern is running
    output logic                    carrier_low    // settled at residual amplitude
);
    import tsh_pkg::*;

    // ****************************************************************
    // bus side: address phase capture
    // ****************************************************************
    logic        wr_pend_reg;
    logic [7:0]  wr_idx_reg;

    logic        rd_take;
    logic        wr_take;

    logic        addr_ok;
    logic [7:0]  addr_idx;

    logic [31:0] hrdata_reg;

    logic        hreadyout_reg;
    logic        hresp_reg;

    tsh_byte_t typeb212_edge_kind_reg;
    tsh_byte_t typeb212_edge_shape_select_reg;
    tsh_byte_t typeb212_edge_duration_reg;
    tsh_byte_t typeb424_residual_amplitude_reg;

    tsh_byte_t typeb212_edge_kind_next;
    tsh_byte_t typeb212_edge_shape_select_next;
    tsh_byte_t typeb212_edge_duration_next;
    tsh_byte_t typeb424_residual_amplitude_next;
    logic [7:0] rd_byte;

    assign addr_ok  = (haddr[31:10] == 22'h00_0000) && (haddr[1:0] == 2'b00);
    assign addr_idx = haddr[9:2];

    assign rd_take  = hsel && htrans[1] && hready && !hwrite;
    assign wr_take  = hsel && htrans[1] && hready && hwrite;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_idx_reg  <= 8'h00;
        end else if (hready) begin
            wr_pend_reg <= wr_take && addr_ok;
            wr_idx_reg  <= addr_idx;
        end
    end

    // ****************************************************************
    // register write data, reserved bits dropped
    // ****************************************************************
    always_comb begin
        typeb212_edge_kind_next          = typeb212_edge_kind_reg;
        typeb212_edge_shape_select_next  = typeb212_edge_shape_select_reg;
        typeb212_edge_duration_next      = typeb212_edge_duration_reg;
        typeb424_residual_amplitude_next = typeb424_residual_amplitude_reg;
        if (wr_pend_reg) begin
            case (wr_idx_reg)
                `TSH_IDX_KIND: begin
                    typeb212_edge_kind_next = hwdata[7:0];
                end
                `TSH_IDX_SHAPE: begin
                    typeb212_edge_shape_select_next = hwdata[7:0] & `TSH_SHAPE_MASK;
                end
                `TSH_IDX_DURATION: begin
                    typeb212_edge_duration_next = hwdata[7:0] & `TSH_DUR_MASK;
                end
                `TSH_IDX_RESIDUAL: begin
                    typeb424_residual_amplitude_next = hwdata[7:0];
                end
                default: begin
                    typeb212_edge_kind_next = typeb212_edge_kind_reg;
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            typeb212_edge_kind_reg          <= `TSH_RST_KIND;
            typeb212_edge_shape_select_reg  <= `TSH_RST_SHAPE;
            typeb212_edge_duration_reg      <= `TSH_RST_DURATION;
            typeb424_residual_amplitude_reg <= `TSH_RST_RESIDUAL;
        end else begin
            typeb212_edge_kind_reg          <= typeb212_edge_kind_next;
            typeb212_edge_shape_select_reg  <= typeb212_edge_shape_select_next;
            typeb212_edge_duration_reg      <= typeb212_edge_duration_next;
            typeb424_residual_amplitude_reg <= typeb424_residual_amplitude_next;
        end
    end

    // ****************************************************************
    // read data from post-write values
    // so a read after a write sees the new byte
    // ****************************************************************
    always_comb begin
        rd_byte = 8'h00;
        if (addr_ok) begin
            case (addr_idx)
                `TSH_IDX_KIND: begin
                    rd_byte = typeb212_edge_kind_next;
                end
                `TSH_IDX_SHAPE: begin
                    rd_byte = typeb212_edge_shape_select_next;
                end
                `TSH_IDX_DURATION: begin
                    rd_byte = typeb212_edge_duration_next;
                end
                `TSH_IDX_RESIDUAL: begin
                    rd_byte = typeb424_residual_amplitude_next;
                end
                default: begin
                    rd_byte = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_reg <= 32'h0000_0000;
        end else if (rd_take) begin
            hrdata_reg <= {24'h00_0000, rd_byte};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_reg <= 1'b1;
            hresp_reg     <= 1'b0;
        end else begin
            hreadyout_reg <= 1'b1;
            hresp_reg     <= 1'b0;
        end
    end

    assign hrdata    = hrdata_reg;

    assign hreadyout = hreadyout_reg;
    assign hresp     = hresp_reg;

    // ****************************************************************
    // field decode of the edge settings
    // ****************************************************************
    tsh_code_t  fall_code;
    tsh_code_t  rise_code;

    logic [2:0] fall_shape;
    logic [2:0] rise_shape;

    logic       dur_scale;
    tsh_step_t  dur_count;

    assign fall_code  = typeb212_edge_kind_reg[`TSH_KIND_FALL_HI:`TSH_KIND_FALL_LO];
    assign rise_code  = typeb212_edge_kind_reg[`TSH_KIND_RISE_HI:`TSH_KIND_RISE_LO];

    assign fall_shape = typeb212_edge_shape_select_reg[`TSH_SHAPE_FALL_HI:`TSH_SHAPE_FALL_LO];
    assign rise_shape = typeb212_edge_shape_select_reg[`TSH_SHAPE_RISE_HI:`TSH_SHAPE_RISE_LO];

    assign dur_scale  = typeb212_edge_duration_reg[`TSH_DUR_SCALE_BIT];
    assign dur_count  = typeb212_edge_duration_reg[`TSH_DUR_COUNT_HI:`TSH_DUR_COUNT_LO];

    // ****************************************************************
    // edge sequencer
    // ****************************************************************
    tsh_state_t state_reg;
    tsh_state_t state_next;

    tsh_step_t  step_reg;
    logic       hold_reg;

    logic       state_done;
    logic       last_step;

    // a state lasts one tick, or two when scaled
    assign state_done = carrier_tick && (!dur_scale || hold_reg);
    assign last_step  = (step_reg + 5'd1) >= dur_count;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            TSH_ST_HIGH: begin
                if (mod_request) begin
                    state_next = (dur_count == 5'd0) ? TSH_ST_LOW : TSH_ST_FALL;
                end
            end
            TSH_ST_FALL: begin
                if (state_done && last_step) begin
                    state_next = TSH_ST_LOW;
                end
            end
            TSH_ST_LOW: begin
                if (!mod_request) begin
                    state_next = (dur_count == 5'd0) ? TSH_ST_HIGH : TSH_ST_RISE;
                end
            end
            TSH_ST_RISE: begin
                if (state_done && last_step) begin
                    state_next = TSH_ST_HIGH;
                end
            end
            default: begin
                state_next = TSH_ST_HIGH;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= TSH_ST_HIGH;
        end else begin
            state_reg <= state_next;
        end
    end

    // step counter and half-state marker for the doubled duration
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            step_reg <= 5'd0;
            hold_reg <= 1'b0;
        end else if (state_next != state_reg) begin
            step_reg <= 5'd0;
            hold_reg <= 1'b0;
        end else if (state_reg == TSH_ST_FALL || state_reg == TSH_ST_RISE) begin
            if (state_done) begin
                step_reg <= 5'(step_reg + 5'd1);
                hold_reg <= 1'b0;
            end else if (carrier_tick) begin
                hold_reg <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // amplitude of the running state
    // ****************************************************************
    logic       in_rise;
    tsh_code_t  edge_code;
    logic [2:0] edge_shape;

    logic [7:0] shaped_level;

    assign in_rise    = (state_reg == TSH_ST_RISE);

    assign edge_code  = in_rise ? rise_code : fall_code;
    assign edge_shape = in_rise ? rise_shape : fall_shape;

    // codes 1..3 ramps, 4..6 tables, others a hard step
    tsh_edge_profile u_profile (
        .code      (edge_code),
        .shape     (edge_shape),
        .step      (step_reg),
        .count     (dur_count),
        .rising    (in_rise),
        .low_level (typeb424_residual_amplitude_reg),
        .vdd_level (power_amp_supply_voltage),
        .level     (shaped_level)
    );

    tsh_byte_t amp_level_reg;

    logic      edge_active_reg;
    logic      carrier_low_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            amp_level_reg <= `TSH_FULL_AMPL;
        end else begin
            case (state_reg)
                TSH_ST_HIGH: begin
                    amp_level_reg <= `TSH_FULL_AMPL;
                end
                TSH_ST_LOW: begin
                    amp_level_reg <= typeb424_residual_amplitude_reg;
                end
                TSH_ST_FALL, TSH_ST_RISE: begin
                    amp_level_reg <= shaped_level;
                end
                default: begin
                    amp_level_reg <= `TSH_FULL_AMPL;
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            edge_active_reg <= 1'b0;
            carrier_low_reg <= 1'b0;
        end else begin
            edge_active_reg <= (state_reg == TSH_ST_FALL) || (state_reg == TSH_ST_RISE);
            carrier_low_reg <= (state_reg == TSH_ST_LOW);
        end
    end

    assign amp_level   = amp_level_reg;

    assign edge_active = edge_active_reg;
    assign carrier_low = carrier_low_reg;

endmodule

/* File: core/tsh_pkg.sv */
// Purpose: shared types of the type-B edge shaper
// Assumes: constants live in tsh_cfg.svh
// Notes:   types only
package tsh_pkg;

    typedef logic [7:0] tsh_byte_t;
    typedef logic [3:0] tsh_code_t;
    typedef logic [4:0] tsh_step_t;

    typedef enum logic [1:0] {
        TSH_ST_HIGH,
        TSH_ST_FALL,
        TSH_ST_LOW,
        TSH_ST_RISE
    } tsh_state_t;

endpackage

/* File: tb/test_tsh_edge_shaper.sv */
// Purpose: register and edge tests of the type-B edge shaper
// Assumes: zero wait-state bus, hready looped from hreadyout
// Notes:   carrier ticks spaced four clocks apart
`timescale 1ns/1ps
`include "tsh_cfg.svh"
module test_tsh_edge_shaper;
    import tsh_pkg::*;
    // ****************************************************************
    // signals, tables, tasks
    // ****************************************************************
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        carrier_tick;
    logic        mod_request;
    tsh_byte_t   vdd;
    tsh_byte_t   amp_level;
    logic        edge_active;
    logic        carrier_low;
    logic [31:0] r;
    int          errors;
    int          checks;
    logic [7:0]  rst_t [4] = '{8'h11, 8'h00, 8'h08, 8'h00};
    logic [7:0]  msk_t [4] = '{8'hFF, 8'h77, 8'h9F, 8'hA5};
    logic [7:0]  kt [7] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h16};
    logic [7:0]  st [7] = '{8'h00, 8'h55, 8'h70, 8'h03, 8'h12, 8'h31, 8'h62};
    logic [7:0]  dt [7] = '{8'h03, 8'h81, 8'h05, 8'hE2, 8'h1F, 8'h00, 8'h9F};
    logic [7:0]  rt [7] = '{8'h40, 8'h00, 8'hFF, 8'h80, 8'h20, 8'h10, 8'hC0};

    tsh_edge_shaper u_tsh_edge_shaper (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .carrier_tick(carrier_tick), .mod_request(mod_request),
        .power_amp_supply_voltage(vdd), .amp_level(amp_level),
        .edge_active(edge_active), .carrier_low(carrier_low)
    );

    task automatic check(logic [31:0] seen, logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic bus(logic wr, logic [7:0] idx, logic [7:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {22'h0, idx, 2'b00};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= {24'h00_0000, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask

    task automatic run_edge(logic lvl, logic [7:0] dur, logic [7:0] res);
        int         n;
        logic [6:0] exp;
        n = 0;
        exp = {2'b00, dur[4:0]} << dur[7];
        mod_request <= lvl;
        repeat (3) @(posedge hclk);
        check(edge_active, exp != 7'h00);
        for (int k = 0; k < 70 && edge_active === 1'b1; k++) begin
            carrier_tick <= 1'b1;
            @(posedge hclk);
            carrier_tick <= 1'b0;
            if (edge_active === 1'b1) n++;
            repeat (3) @(posedge hclk);
        end
        repeat (3) @(posedge hclk);
        check(n, exp);
        check(carrier_low, lvl);
        check(amp_level, lvl ? res : 8'hFF);
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    initial begin
        #200000;
        errors++;
        print_verdict();
    end

    // ****************************************************************
    // test sequence
    // ****************************************************************
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0000_0000;
        carrier_tick = 1'b0;
        mod_request = 1'b0;
        vdd = 8'h80;
        errors = 0;
        checks = 0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int i = 0; i < 4; i++) begin
            bus(1'b0, `TSH_IDX_KIND + 8'(i), 8'h00, r);
            check(r, {24'h00_0000, rst_t[i]});
        end
        $display("test reset values done");
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, `TSH_IDX_KIND + 8'(i), (i == 3) ? 8'hA5 : 8'hFF, r);
            bus(1'b0, `TSH_IDX_KIND + 8'(i), 8'h00, r);
            check(r, {24'h00_0000, msk_t[i]});
        end
        bus(1'b1, 8'h2D, 8'h5A, r);
        bus(1'b0, 8'h2D, 8'h00, r);
        check(r, 32'h0000_0000);
        $display("test reserved bits done");
        for (int i = 0; i < 7; i++) begin
            bus(1'b1, `TSH_IDX_KIND, kt[i], r);
            bus(1'b1, `TSH_IDX_SHAPE, st[i], r);
            bus(1'b1, `TSH_IDX_DURATION, dt[i], r);
            bus(1'b1, `TSH_IDX_RESIDUAL, rt[i], r);
            vdd <= 8'h70 + 8'(i * 16);
            run_edge(1'b1, dt[i], rt[i]);
            run_edge(1'b0, dt[i], rt[i]);
        end
        $display("test edges done");
        print_verdict();
    end
endmodule

/* File: tb/tsh_edge_shaper_properties.sv */
// Purpose: port assertions of the type-B edge shaper
// Assumes: zero wait states, one 8-bit register per bus word
// Notes:   shadows follow bus writes to duration and residual
`timescale 1ns/1ps
`include "tsh_cfg.svh"
module tsh_edge_shaper_properties (
    input wire logic               hclk,         // clock
    input wire logic               hresetn,      // reset, active low
    input wire logic               hsel,         // select
    input wire logic [31:0]        haddr,        // address
    input wire logic [1:0]         htrans,       // transfer type
    input wire logic               hwrite,       // write
    input wire logic [2:0]         hsize,        // size
    input wire logic               hready,       // ready in
    input wire logic [31:0]        hwdata,       // write data
    input wire logic [31:0]        hrdata,       // read data
    input wire logic               hreadyout,    // ready out
    input wire logic               hresp,        // response
    input wire logic               carrier_tick, // carrier pulse
    input wire logic               mod_request,  // modulation request
    input wire tsh_pkg::tsh_byte_t power_amp_supply_voltage, // supply
    input wire tsh_pkg::tsh_byte_t amp_level,    // amplitude
    input wire logic               edge_active,  // edge running
    input wire logic               carrier_low   // at residual
);
    import tsh_pkg::*;
    // ****************************************************************
    // shadows and tick counter
    // ****************************************************************
    logic [7:0] ph_idx;
    logic       ph_wr;
    logic       ph_rd;
    logic [7:0] dur_q;
    logic [7:0] res_q;
    logic [6:0] tick_cnt;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_wr <= 1'b0;
            ph_rd <= 1'b0;
            ph_idx <= 8'h00;
        end else begin
            ph_wr <= hsel & htrans[1] & hready & hwrite;
            ph_rd <= hsel & htrans[1] & hready & !hwrite;
            ph_idx <= haddr[9:2];
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dur_q <= `TSH_RST_DURATION;
            res_q <= `TSH_RST_RESIDUAL;
        end else if (ph_wr && ph_idx == `TSH_IDX_DURATION) begin
            dur_q <= hwdata[7:0] & `TSH_DUR_MASK;
        end else if (ph_wr && ph_idx == `TSH_IDX_RESIDUAL) begin
            res_q <= hwdata[7:0];
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_cnt <= 7'h00;
        end else if (!edge_active) begin
            tick_cnt <= 7'h00;
        end else if (carrier_tick) begin
            tick_cnt <= tick_cnt + 7'h01;
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_ready_always: assert property (hreadyout && !hresp)
        else $error("bus not ready or not okay");
    a_upper_zero: assert property (hrdata[31:8] == 24'h00_0000)
        else $error("read data upper bits set");
    a_read_duration: assert property (
        ph_rd && ph_idx == `TSH_IDX_DURATION |-> hrdata[7:0] == dur_q)
        else $error("duration read back wrong");
    a_single_state: assert property (
        $fell(edge_active) && !dur_q[7] |-> tick_cnt == {2'b00, dur_q[4:0]})
        else $error("edge length wrong, scale clear");
    a_double_state: assert property (
        $fell(edge_active) && dur_q[7] |-> tick_cnt == {1'b0, dur_q[4:0], 1'b0})
        else $error("edge length wrong, scale set");
    a_no_zero_edge: assert property ($rose(edge_active) |-> dur_q[4:0] != 5'h00)
        else $error("edge run with zero states");
    a_low_residual: assert property (carrier_low |-> amp_level == res_q)
        else $error("low amplitude not residual");
    a_edge_range: assert property (edge_active |-> amp_level >= res_q)
        else $error("edge below residual");
    a_high_full: assert property (
        !edge_active && !carrier_low && $past(!edge_active && !carrier_low)
        |-> amp_level == 8'hFF)
        else $error("idle amplitude not full");
    a_low_excl: assert property (carrier_low |-> !edge_active)
        else $error("edge active while settled low");
    a_start_cause: assert property (
        $rose(edge_active) |-> $past(mod_request, 2) != $past(carrier_low, 2))
        else $error("edge started without request");
    c_double: cover property ($fell(edge_active) && dur_q[7]);
    c_low: cover property ($rose(carrier_low));
    c_read: cover property (ph_rd && ph_idx == `TSH_IDX_DURATION);
endmodule

bind tsh_edge_shaper tsh_edge_shaper_properties u_tsh_edge_shaper_properties (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready, .hwdata,
    .hrdata, .hreadyout, .hresp, .carrier_tick, .mod_request,
    .power_amp_supply_voltage, .amp_level, .edge_active, .carrier_low
);
